// [hdl/clb_consts.vh]
`ifndef CLB_CONSTS_VH
`define CLB_CONSTS_VH

// Internal cycle kinds requested by the core
`define CLB_KIND_MEM_RD     3'h0
`define CLB_KIND_MEM_RD_LK  3'h1
`define CLB_KIND_MEM_WR     3'h2
`define CLB_KIND_MEM_WR_LK  3'h3
`define CLB_KIND_IO_RD      3'h4
`define CLB_KIND_IO_WR      3'h5
`define CLB_KIND_INTA       3'h6
`define CLB_KIND_HALT       3'h7

// Definition codes, bit order {memory_io, data_control, write_read}
`define CLB_DEF_MEM_RD      3'h6
`define CLB_DEF_MEM_WR      3'h7
`define CLB_DEF_IO_RD       3'h2
`define CLB_DEF_IO_WR       3'h3
`define CLB_DEF_INTA        3'h0
`define CLB_DEF_HALT        3'h5
`define CLB_DEF_RST         3'h0

// Operand sizes
`define CLB_SIZE_BYTE       2'h0
`define CLB_SIZE_WORD       2'h1
`define CLB_SIZE_DWORD      2'h2

// Byte masks and lane halves
`define CLB_MASK_BYTE       8'h01
`define CLB_MASK_WORD       8'h03
`define CLB_MASK_DWORD      8'h0f
`define CLB_BE_HIGH_HALF    4'hc
`define CLB_BE_LOW_HALF     4'h3

// Reset values of bus outputs (active-low lines negated)
`define CLB_BE_N_RST        4'hf
`define CLB_ADDR_RST        30'h0

// Clocks of clk_sys_i per bus state
`define CLB_CLKS_PER_STATE  2

`endif

// [hdl/clb_phase_gen.v]
`timescale 1ns/100ps
`default_nettype none

// Bus state phase: phase one then phase two, one clock each
module clb_phase_gen (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire sys_rst_i,
  input  wire ce_i,
  // Phase
  output reg  ph_o
);

  // Toggle per enabled clock; two clocks make one bus state
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ph_o <= 1'b0;
    end else if (ce_i) begin
      ph_o <= ~ph_o; // RQ7
    end
  end

endmodule // clb_phase_gen

`default_nettype wire

// [hdl/clb_lane_steer.v]
`timescale 1ns/100ps
`default_nettype none

// Data lane steering for the half-width bus
module clb_lane_steer (
  // Write side
  input  wire [31:0] wdata_i,
  input  wire [3:0]  be_i,
  output reg  [31:0] wlanes_o,
  // Read side
  input  wire        half_i,
  input  wire [31:0] rlanes_i,
  output reg  [31:0] rdata_o
);

  // High bytes only: copy onto low lanes so a narrow device sees them
  always @* begin
    if (be_i[1:0] == 2'h0) begin
      wlanes_o = {wdata_i[31:16], wdata_i[31:16]}; // RQ17
    end else begin
      wlanes_o = wdata_i;
    end
  end

  // Narrow device returns upper bytes on the low lanes
  always @* begin
    if (half_i && (be_i[1:0] == 2'h0)) begin
      rdata_o = {rlanes_i[15:0], rlanes_i[15:0]}; // RQ17
    end else begin
      rdata_o = rlanes_i;
    end
  end

endmodule // clb_lane_steer

`default_nettype wire

// [hdl/clb_cycle_engine.v]
// Function
// RQ1 - Definition outputs and address drive every cycle
// RQ2 - Address strobe marks each new cycle start
// RQ3 - Eight cycle kinds supported
// RQ4 - All kinds run on 32 or 16 bits
// RQ5 - Idle once last cycle ended, no strobe
// RQ6 - Hold grant output asserted in hold
// RQ7 - Bus state equals two fast clocks
// RQ8 - Shortest cycle: address state, data state
// RQ9 - Wait states repeat until acknowledge sampled
// RQ10 - Pipelining chosen per cycle by request
// RQ11 - Non-pipelined: address held whole cycle
// RQ12 - Pipelined: next address early with strobe
// RQ13 - Pipelined cycle: two states, pipelined pair
// RQ14 - First cycle after idle never pipelined
// RQ15 - Early address only with pending request
// RQ16 - Width select read near cycle end
// RQ17 - Extra half cycle moves upper data low
// RQ18 - External logic acknowledges when access done
// RQ19 - Read data in, write data out
// RQ20 - Sample acknowledge each data state end
// RQ21 - Extra half cycle negates low enables
// RQ22 - After acknowledge: address, idle or hold
// RQ23 - High-order first, half split low first
// RQ24 - Reset to idle, strobe and grant off
`timescale 1ns/100ps
`default_nettype none
`include "clb_consts.vh"

module clb_cycle_engine #(
  parameter AW = 30
) (
  // Clock, reset, enable
  input  wire          clk_sys_i,
  input  wire          sys_rst_i,
  input  wire          ce_i,
  // Core request side
  input  wire          req_valid_i,
  input  wire [2:0]    req_kind_i,
  input  wire [AW+1:0] req_addr_i,
  input  wire [1:0]    req_size_i,
  input  wire [31:0]   req_wdata_i,
  output reg           req_ready_o,
  output reg           done_o,
  output reg  [31:0]   rdata_o,
  // Bus address and definition
  output reg           address_strobe_n_o,
  output reg  [3:0]    byte_lane_enables_n_o,
  output reg  [AW-1:0] dword_address_o,
  output reg           memory_io_select_o,
  output reg           write_read_select_o,
  output reg           data_control_select_o,
  output reg           lock_n_o,
  // Bus data
  input  wire [31:0]   data_i,
  output reg  [31:0]   data_o,
  output reg           data_oe_o,
  // Bus control inputs
  input  wire          cycle_acknowledge_n_i,
  input  wire          next_address_request_n_i,
  input  wire          half_width_bus_select_n_i,
  input  wire          hold_request_i,
  // Bus status
  output reg           hold_grant_out_o,
  output reg           bus_idle_o
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_T1   = 6'h02;
  localparam [5:0] S_T2   = 6'h04;
  localparam [5:0] S_T1P  = 6'h08;
  localparam [5:0] S_T2P  = 6'h10;
  localparam [5:0] S_HOLD = 6'h20;

  // Byte mask of an operand over two dwords
  function [7:0] op_mask;
    input [1:0] size;
    input [1:0] shift;
    reg   [7:0] m;
    begin
      case (size)
        `CLB_SIZE_BYTE: m = `CLB_MASK_BYTE;
        `CLB_SIZE_WORD: m = `CLB_MASK_WORD;
        default:        m = `CLB_MASK_DWORD;
      endcase
      op_mask = m << shift;
    end
  endfunction

  // Definition code of a kind
  function [2:0] kind_def;
    input [2:0] kind;
    begin
      case (kind)
        `CLB_KIND_MEM_RD, `CLB_KIND_MEM_RD_LK: kind_def = `CLB_DEF_MEM_RD;
        `CLB_KIND_MEM_WR, `CLB_KIND_MEM_WR_LK: kind_def = `CLB_DEF_MEM_WR;
        `CLB_KIND_IO_RD:                       kind_def = `CLB_DEF_IO_RD;
        `CLB_KIND_IO_WR:                       kind_def = `CLB_DEF_IO_WR;
        `CLB_KIND_INTA:                        kind_def = `CLB_DEF_INTA;
        default:                               kind_def = `CLB_DEF_HALT;
      endcase
    end
  endfunction

  reg  [5:0]    st_ff;
  reg  [5:0]    nxt_st;
  reg  [7:0]    op_rem_ff;
  reg  [7:0]    nxt_rem;
  reg  [2:0]    op_kind_ff;
  reg  [AW-1:0] op_base_ff;
  reg  [1:0]    op_shift_ff;
  reg  [63:0]   op_w64_ff;
  reg  [3:0]    cur_be_ff;
  reg           cur_hi_ff;
  reg           cur_wr_ff;
  reg           cur_last_ff;
  reg  [1:0]    cur_shift_ff;
  reg  [31:0]   cur_wdata_ff;
  reg  [3:0]    pipe_be_ff;
  reg           pipe_hi_ff;
  reg           pipe_wr_ff;
  reg           pipe_last_ff;
  reg  [1:0]    pipe_shift_ff;
  reg  [31:0]   pipe_wdata_ff;
  reg           na_ff;
  reg  [63:0]   asm_ff;
  reg  [63:0]   asm_mrg;
  integer       i;

  wire          ph;
  wire [31:0]   wlanes;
  wire [31:0]   rlanes;

  clb_phase_gen u_phase (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .ph_o      (ph)
  );

  // Status sampled at each data state end
  wire ce_end   = ce_i & ph;
  wire ack      = ~cycle_acknowledge_n_i;
  wire half     = ~half_width_bus_select_n_i; // RQ4
  wire in_t2    = (st_ff == S_T2) | (st_ff == S_T2P);
  wire in_data  = in_t2 | (st_ff == S_T1P);
  wire both_hv  = (|cur_be_ff[1:0]) & (|cur_be_ff[3:2]);
  wire split    = half & both_hv; // RQ16
  wire ack_end  = ce_end & in_data & ack; // RQ20
  wire resplit  = ce_end & in_t2 & ack & split;
  wire pending  = |op_rem_ff;
  // Pipelining skipped when a half split is still possible
  wire can_pipe = na_ff & pending & ~both_hv; // RQ15
  wire accept   = ce_i & req_valid_i & req_ready_o;

  // Next piece: upper dword first, whole dword half together
  wire          pc_hi   = |op_rem_ff[7:4]; // RQ23
  wire [3:0]    pc_be   = pc_hi ? op_rem_ff[7:4] : op_rem_ff[3:0];
  wire [7:0]    pc_mask = pc_hi ? {pc_be, 4'h0} : {4'h0, pc_be};
  wire [AW-1:0] pc_addr = op_base_ff + {{(AW-1){1'b0}}, pc_hi};
  wire [31:0]   pc_data = pc_hi ? op_w64_ff[63:32] : op_w64_ff[31:0];
  wire          pc_last = ((op_rem_ff & ~pc_mask) == 8'h0);
  wire [2:0]    pc_def  = kind_def(op_kind_ff);
  wire          pc_lock = (op_kind_ff == `CLB_KIND_MEM_RD_LK) |
                          (op_kind_ff == `CLB_KIND_MEM_WR_LK);

  // Bus state transitions at the end of each bus state
  always @* begin
    nxt_st = st_ff;
    if (ce_end) begin
      case (st_ff)
        S_IDLE: begin
          if (hold_request_i) begin
            nxt_st = S_HOLD;
          end else if (pending) begin
            nxt_st = S_T1; // RQ14
          end
        end
        S_T1: begin
          nxt_st = S_T2; // RQ8
        end
        S_T2, S_T2P: begin
          if (ack && split) begin
            nxt_st = S_T1; // RQ17
          end else if (ack && hold_request_i) begin
            nxt_st = S_HOLD; // RQ22
          end else if (ack && pending) begin
            nxt_st = S_T1; // RQ22
          end else if (ack) begin
            nxt_st = S_IDLE; // RQ22
          end else if (can_pipe) begin
            nxt_st = S_T1P; // RQ10
          end
        end
        S_T1P: begin
          if (ack) begin
            nxt_st = S_T2P; // RQ13
          end
        end
        S_HOLD: begin
          if (!hold_request_i) begin
            nxt_st = S_IDLE;
          end
        end
        default: begin
          nxt_st = S_IDLE;
        end
      endcase
    end
  end

  wire issue   = ce_end & (((nxt_st == S_T1) & ~resplit) |
                           ((nxt_st == S_T1P) & (st_ff != S_T1P)));
  wire to_pipe = issue & (nxt_st == S_T1P);

  // Remaining operand bytes
  always @* begin
    nxt_rem = op_rem_ff;
    if (issue) begin
      nxt_rem = op_rem_ff & ~pc_mask;
    end
    if (accept) begin
      nxt_rem = op_mask(req_size_i, req_addr_i[1:0]);
    end
  end

  clb_lane_steer u_steer (
    .wdata_i  (cur_wdata_ff),
    .be_i     (cur_be_ff),
    .wlanes_o (wlanes),
    .half_i   (half),
    .rlanes_i (data_i),
    .rdata_o  (rlanes)
  );

  // Read bytes merged into the operand assembly
  always @* begin
    asm_mrg = asm_ff;
    for (i = 0; i < 4; i = i + 1) begin
      if (cur_be_ff[i] && !(split && i > 1)) begin
        asm_mrg[({cur_hi_ff, 2'b00} + i) * 8 +: 8] = rlanes[i*8 +: 8];
      end
    end
  end

  // Sequencer registers
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_ff                 <= S_IDLE; // RQ24
      op_rem_ff             <= 8'h0;
      op_kind_ff            <= 3'h0;
      op_base_ff            <= {AW{1'b0}};
      op_shift_ff           <= 2'h0;
      op_w64_ff             <= 64'h0;
      cur_be_ff             <= 4'h0;
      cur_hi_ff             <= 1'b0;
      cur_wr_ff             <= 1'b0;
      cur_last_ff           <= 1'b0;
      cur_shift_ff          <= 2'h0;
      cur_wdata_ff          <= 32'h0;
      pipe_be_ff            <= 4'h0;
      pipe_hi_ff            <= 1'b0;
      pipe_wr_ff            <= 1'b0;
      pipe_last_ff          <= 1'b0;
      pipe_shift_ff         <= 2'h0;
      pipe_wdata_ff         <= 32'h0;
      na_ff                 <= 1'b0;
      asm_ff                <= 64'h0;
      req_ready_o           <= 1'b1;
      done_o                <= 1'b0;
      rdata_o               <= 32'h0;
      address_strobe_n_o    <= 1'b1; // RQ24
      byte_lane_enables_n_o <= `CLB_BE_N_RST;
      dword_address_o       <= `CLB_ADDR_RST;
      memory_io_select_o    <= 1'b0;
      write_read_select_o   <= 1'b0;
      data_control_select_o <= 1'b0;
      lock_n_o              <= 1'b1;
      data_o                <= 32'h0;
      data_oe_o             <= 1'b0;
      hold_grant_out_o      <= 1'b0; // RQ24
      bus_idle_o            <= 1'b1;
    end else if (ce_i) begin
      st_ff       <= nxt_st;
      op_rem_ff   <= nxt_rem;
      req_ready_o <= (nxt_rem == 8'h0);
      done_o      <= 1'b0;
      // Take a new operand; dword index is the base of the pair
      if (accept) begin
        op_kind_ff  <= req_kind_i; // RQ3
        op_base_ff  <= req_addr_i[AW+1:2];
        op_shift_ff <= req_addr_i[1:0];
        op_w64_ff   <= {32'h0, req_wdata_i} << {req_addr_i[1:0], 3'b000};
      end
      // Strobe stands for the whole address state
      if (ce_end) begin
        address_strobe_n_o <= ~(issue | resplit); // RQ2 RQ12
      end
      // Drive new address and definition; held until next issue, except enables, which a half split also changes
      if (issue) begin
        byte_lane_enables_n_o <= ~pc_be; // RQ1 RQ11
        dword_address_o       <= pc_addr; // RQ1
        memory_io_select_o    <= pc_def[2];
        data_control_select_o <= pc_def[1];
        write_read_select_o   <= pc_def[0];
        lock_n_o              <= ~pc_lock;
        na_ff                 <= 1'b0;
        if (to_pipe) begin
          pipe_be_ff    <= pc_be; // RQ12
          pipe_hi_ff    <= pc_hi;
          pipe_wr_ff    <= pc_def[0];
          pipe_last_ff  <= pc_last;
          pipe_shift_ff <= op_shift_ff;
          pipe_wdata_ff <= pc_data;
        end else begin
          cur_be_ff    <= pc_be;
          cur_hi_ff    <= pc_hi;
          cur_wr_ff    <= pc_def[0];
          cur_last_ff  <= pc_last;
          cur_shift_ff <= op_shift_ff;
          cur_wdata_ff <= pc_data;
        end
      end
      // Second half cycle: same address, low enables negated
      if (resplit) begin
        byte_lane_enables_n_o <= ~(cur_be_ff & `CLB_BE_HIGH_HALF); // RQ21
        cur_be_ff             <= cur_be_ff & `CLB_BE_HIGH_HALF; // RQ21
        na_ff                 <= 1'b0;
      end
      // Next-address request sampled at end of phase one
      if (!ph && in_t2 && !next_address_request_n_i) begin
        na_ff <= 1'b1; // RQ10
      end
      // Acknowledged cycle: capture, finish, promote pipelined cycle
      if (ack_end) begin
        if (!cur_wr_ff) begin
          asm_ff <= asm_mrg; // RQ19 RQ20
        end
        if (cur_last_ff && !(in_t2 && split)) begin
          done_o  <= 1'b1;
          rdata_o <= asm_mrg[{cur_shift_ff, 3'b000} +: 32];
          asm_ff  <= 64'h0;
        end
        if (st_ff == S_T1P) begin
          cur_be_ff    <= pipe_be_ff; // RQ13
          cur_hi_ff    <= pipe_hi_ff;
          cur_wr_ff    <= pipe_wr_ff;
          cur_last_ff  <= pipe_last_ff;
          cur_shift_ff <= pipe_shift_ff;
          cur_wdata_ff <= pipe_wdata_ff;
        end
      end
      // Write data stays out one phase past the acknowledge
      data_o    <= wlanes; // RQ19
      data_oe_o <= cur_wr_ff & ((st_ff == S_T1) | in_data); // RQ20
      // Wait states: without acknowledge only a pipelined issue, a newly taken operand or the next-address sample changes anything above
      hold_grant_out_o <= (nxt_st == S_HOLD); // RQ6
      bus_idle_o       <= (nxt_st == S_IDLE); // RQ5 RQ9
    end
  end

endmodule // clb_cycle_engine

`default_nettype wire

// [bench/clb_cycle_engine_chk.sv]
`timescale 1ns/100ps
`default_nettype none

// Bus-side properties of the cycle engine
module clb_cycle_engine_chk #(
  parameter AW = 30
) (
  // Clock and reset
  input wire logic          clk_sys_i,
  input wire logic          sys_rst_i,
  // Address and definition
  input wire logic          address_strobe_n_o,
  input wire logic [3:0]    byte_lane_enables_n_o,
  input wire logic [AW-1:0] dword_address_o,
  input wire logic          memory_io_select_o,
  input wire logic          write_read_select_o,
  input wire logic          data_control_select_o,
  // Control and status
  input wire logic          cycle_acknowledge_n_i,
  input wire logic          hold_request_i,
  input wire logic          done_o,
  input wire logic          hold_grant_out_o,
  input wire logic          bus_idle_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // One address state, then one data state
  sequence s_addr_st;
    !address_strobe_n_o [*2];
  endsequence
  sequence s_data_st;
    address_strobe_n_o [*2];
  endsequence

  a_strobe_two_clk: assert property (
    $fell(address_strobe_n_o) |-> s_addr_st ##1 address_strobe_n_o)
    else $error("strobe not one bus state long");
  a_idle_first_np: assert property (
    $fell(address_strobe_n_o) && $past(bus_idle_o) |->
    (s_addr_st ##1 s_data_st) and (!done_o [*4]))
    else $error("cycle after idle not plain two-state");
  a_addr_held: assert property (
    !$stable({byte_lane_enables_n_o, dword_address_o, memory_io_select_o,
      write_read_select_o, data_control_select_o}) |-> $fell(address_strobe_n_o))
    else $error("address changed without strobe");
  a_done_on_ack: assert property (
    done_o |-> !$past(cycle_acknowledge_n_i))
    else $error("completion without acknowledge");
  a_grant_quiet: assert property (
    hold_grant_out_o |-> address_strobe_n_o && !bus_idle_o)
    else $error("strobe or idle during hold");
  a_idle_quiet: assert property (
    bus_idle_o |-> address_strobe_n_o)
    else $error("strobe while idle");
  a_grant_cause: assert property (
    $rose(hold_grant_out_o) |-> $past(hold_request_i))
    else $error("grant without hold request");
  a_grant_drop: assert property (
    $fell(hold_request_i) |-> ##[0:4] !hold_grant_out_o)
    else $error("grant kept after hold request");
endmodule // clb_cycle_engine_chk

`default_nettype wire

// [bench/clb_bus_responder.sv]
`timescale 1ns/100ps
`default_nettype none

// Far-side memory, decode and ready logic
module clb_bus_responder (
  // Clock and bus
  input  wire logic        clk_sys_i,
  input  wire logic        strobe_n_i,
  input  wire logic [3:0]  be_n_i,
  // Test settings
  input  wire logic        half_mode_i,
  input  wire logic        na_en_i,
  input  wire logic [1:0]  slow_i,
  input  wire logic [31:0] memv_i,
  // Answers
  output var  logic        ack_n_o,
  output var  logic        na_n_o,
  output wire logic        half_n_o,
  output wire logic [31:0] data_o
);
  logic   st_q = 1'b1;
  logic   bnd = 1'b0;
  integer p_seed = 37;

  // Track bus-state edges, resynced on every new strobe
  always @(posedge clk_sys_i) begin
    st_q <= strobe_n_i;
    bnd  <= (st_q && !strobe_n_i) ? 1'b1 : ~bnd;
  end

  // Levels stand for a whole state; waits drawn per state
  always @(posedge clk_sys_i) begin
    if (bnd) begin
      ack_n_o <= #1 (($random(p_seed) & 3) < slow_i);
      na_n_o  <= #1 !(na_en_i && ($random(p_seed) & 1));
    end
  end

  // A 16-bit device fills only the low lanes; upper lanes carry inverted data
  assign half_n_o = !half_mode_i;
  assign data_o = half_mode_i ? {~memv_i[31:16],
    (be_n_i[1:0] == 2'h3) ? memv_i[31:16] : memv_i[15:0]} : memv_i;
endmodule // clb_bus_responder

`default_nettype wire

// [bench/tb_cpu_local_bus_cycle_engine.sv]
`timescale 1ns/100ps
`default_nettype none
`include "clb_consts.vh"

bind clb_cycle_engine clb_cycle_engine_chk #(.AW(AW)) u_chk (.clk_sys_i, .sys_rst_i,
  .address_strobe_n_o, .byte_lane_enables_n_o, .dword_address_o, .memory_io_select_o,
  .write_read_select_o, .data_control_select_o, .cycle_acknowledge_n_i, .hold_request_i,
  .done_o, .hold_grant_out_o, .bus_idle_o);

module tb_cpu_local_bus_cycle_engine;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0, hold_request_i = 1'b0;
  logic [2:0] req_kind_i = 3'h0;
  logic [1:0] req_size_i = 2'h0, slow = 2'h0;
  logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, memv = 32'h0;
  wire req_ready_o, done_o, address_strobe_n_o, memory_io_select_o, write_read_select_o;
  wire data_control_select_o, lock_n_o, hold_grant_out_o, bus_idle_o, ack_n, na_n, half_n;
  wire [3:0] byte_lane_enables_n_o;
  wire [29:0] dword_address_o;
  wire [31:0] rdata_o, data_rd;
  integer seed = 37, n_errors = 0, check_count = 0, cyc = 0;
  bit half_mode = 0, na_en = 0, hold_en = 0, st_q = 1;
  logic [63:0] exp_q[$], e;
  bit rd_q[$];
  logic [37:0] pq[$];
  logic [33:0] prv = 34'h0;

  clb_cycle_engine #(.AW(30)) DUT (.clk_sys_i, .sys_rst_i, .ce_i(1'b1), .req_valid_i,
    .req_kind_i, .req_addr_i, .req_size_i, .req_wdata_i, .req_ready_o, .done_o, .rdata_o,
    .address_strobe_n_o, .byte_lane_enables_n_o, .dword_address_o, .memory_io_select_o,
    .write_read_select_o, .data_control_select_o, .lock_n_o, .data_i(data_rd), .data_o(),
    .data_oe_o(), .cycle_acknowledge_n_i(ack_n), .next_address_request_n_i(na_n),
    .half_width_bus_select_n_i(half_n), .hold_request_i, .hold_grant_out_o, .bus_idle_o);
  clb_bus_responder u_far (.clk_sys_i, .strobe_n_i(address_strobe_n_o),
    .be_n_i(byte_lane_enables_n_o), .half_mode_i(half_mode), .na_en_i(na_en),
    .slow_i(slow), .memv_i(memv), .ack_n_o(ack_n), .na_n_o(na_n), .half_n_o(half_n),
    .data_o(data_rd));

  always #20 clk_sys_i = ~clk_sys_i;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Operand bytes as an eight-lane mask across two dwords
  function automatic logic [7:0] op_mask(input logic [1:0] sz, input logic [1:0] off);
    op_mask = (sz == `CLB_SIZE_BYTE ? `CLB_MASK_BYTE : sz == `CLB_SIZE_WORD ?
      `CLB_MASK_WORD : `CLB_MASK_DWORD) << off;
  endfunction

  // First cycle of an operand: upper dword piece goes out first
  function automatic logic [37:0] first_cyc(input logic [2:0] k, input logic [31:0] a,
                                            input logic [1:0] sz);
    logic [7:0] m;
    logic [2:0] d;
    m = op_mask(sz, a[1:0]);
    case (k)
      `CLB_KIND_MEM_RD, `CLB_KIND_MEM_RD_LK: d = `CLB_DEF_MEM_RD;
      `CLB_KIND_MEM_WR, `CLB_KIND_MEM_WR_LK: d = `CLB_DEF_MEM_WR;
      `CLB_KIND_IO_RD: d = `CLB_DEF_IO_RD;
      `CLB_KIND_IO_WR: d = `CLB_DEF_IO_WR;
      `CLB_KIND_INTA: d = `CLB_DEF_INTA;
      default: d = `CLB_DEF_HALT;
    endcase
    first_cyc = (m[7:4] != 4'h0) ? {~m[7:4], a[31:2] + 30'h1, d, 1'b1}
                                 : {~m[3:0], a[31:2], d, 1'b1};
    first_cyc[0] = !(k == `CLB_KIND_MEM_RD_LK || k == `CLB_KIND_MEM_WR_LK);
  endfunction

  // Hand one request over and queue what it should produce
  task automatic do_op(input logic [2:0] k, input logic [31:0] a, input logic [1:0] sz);
    int w;
    logic [63:0] r;
    req_kind_i = k;
    req_addr_i = a;
    req_size_i = sz;
    req_wdata_i = $random(seed);
    req_valid_i = 1'b1;
    w = 0;
    do begin
      @(posedge clk_sys_i);
      w++;
    end while (req_ready_o !== 1'b1 && w < 400);
    #1;
    check(w < 400, 1'b1);
    r = {memv, memv} >> {a[1:0], 3'h0};
    pq.push_back(first_cyc(k, a, sz));
    // Upper word of r reused as the operand-size mask; bytes outside it read as zero
    r[63:32] = sz == `CLB_SIZE_BYTE ? 32'hff : sz == `CLB_SIZE_WORD ? 32'hffff : 32'hffffffff;
    exp_q.push_back({r[63:32], r[31:0] & r[63:32]});
    rd_q.push_back(k == 3'h0 || k == 3'h1 || k == 3'h4 || k == 3'h6);
  endtask

  // Let every queued operand finish, then expect an idle bus
  task automatic drain;
    int w;
    w = 0;
    req_valid_i = 1'b0;
    hold_en = 0;
    while (exp_q.size() != 0 && w < 2000) begin
      @(posedge clk_sys_i);
      w++;
    end
    repeat (10) @(posedge clk_sys_i);
    #1;
    check({w < 2000, bus_idle_o, address_strobe_n_o, hold_grant_out_o}, 4'he);
  endtask

  // Completions arrive in issue order
  always @(posedge clk_sys_i) begin
    if (!sys_rst_i && done_o === 1'b1) begin
      e = exp_q.pop_front();
      if (rd_q.pop_front())
        check(rdata_o & e[63:32], e[31:0]);
    end
  end

  // Each strobe: a split repeat, or the first cycle of the next operand
  always @(posedge clk_sys_i) begin
    st_q <= address_strobe_n_o;
    if (!sys_rst_i && st_q && !address_strobe_n_o) begin
      if (half_mode && prv[33:32] != 2'h3 && prv[31:30] != 2'h3)
        check({byte_lane_enables_n_o, dword_address_o}, prv | {4'h3, 30'h0});
      else if (pq.size() != 0)
        check({byte_lane_enables_n_o, dword_address_o, memory_io_select_o,
          data_control_select_o, write_read_select_o, lock_n_o}, pq.pop_front());
      prv <= {byte_lane_enables_n_o, dword_address_o};
    end
  end

  // Hold requests in bursts, only where a batch wants them
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    hold_request_i <= #1 hold_en && cyc[5:3] == 3'h5;
  end

  initial begin
    #(40 * 40000);
    n_errors++;
    close_out;
  end

  // Batches: bus width, pipelining, wait states and hold all varied
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    check({address_strobe_n_o, hold_grant_out_o, bus_idle_o, req_ready_o, done_o},
      5'h16);
    for (int b = 0; b < 6; b++) begin
      half_mode = b[0];
      na_en = !b[0];
      slow = b[2:1];
      hold_en = b >= 4;
      memv = $random(seed);
      for (int i = 0; i < 12; i++) begin
        do_op(i < 8 ? i[2:0] : 3'($random(seed)), {32'($random(seed)) >> 2, i[1:0]},
          i < 8 ? `CLB_SIZE_DWORD : 2'($random(seed)));
        if (b < 2)
          drain();
      end
      drain();
    end
    close_out;
  end
endmodule // tb_cpu_local_bus_cycle_engine

`default_nettype wire
